// ---- src/dfc_defines.svh ----
`ifndef DFC_DEFINES_SVH
`define DFC_DEFINES_SVH
`define DFC_ADR_CTRL 8'h00
`define DFC_ADR_HP_HI 8'h04
`define DFC_ADR_HP_LO 8'h08
`define DFC_ADR_STATUS 8'h0c
`define DFC_ADR_DATA 8'h10
`define DFC_CTRL_PATH_LSB 0
`define DFC_CTRL_RATE_LSB 2
`define DFC_CTRL_PHASE_BIT 5
`define DFC_HP_RESET 16'h0337
`define DFC_MOD_DIV 2'h3
`define DFC_RATE_MAX 3'h4
`define DFC_LOG2N_MAX 3'h7
`define DFC_ORDER 5
`define DFC_NORM_BITS 23
`define DFC_FULL_POS 24'h7fffff
`define DFC_FULL_NEG 24'h800001
`define DFC_COEF_SHIFT 3
`define DFC_HP_SHIFT 16
// tap weights, tap 0 newest, nibble per tap, each set sums to eight
`define DFC_W_HALF 16'h1331
`define DFC_W_S3_LIN 16'h2222
`define DFC_W_S3_MIN 16'h1124
`define DFC_W_S4_LIN 16'h1331
`define DFC_W_S4_MIN 16'h0125
`endif

// ---- src/dfc_pkg.sv ----
package dfc_pkg;
	typedef enum logic [1:0] {
		DFC_PATH_RAW = 2'b00,
		DFC_PATH_SINC = 2'b01,
		DFC_PATH_FIR = 2'b10,
		DFC_PATH_HPF = 2'b11
	} dfc_path_t;
	typedef struct packed {
		logic valid;
		logic [23:0] data;
	} dfc_sample_t;
	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		dfc_path_t path;
		logic [2:0] rate;
		logic phase;
		logic [7:0] hp_hi;
		logic [7:0] hp_lo;
		logic [1:0] div;
		logic half;
		logic flag;
		logic [4:0][36:0] integ;
		logic [4:0][36:0] comb;
		logic [6:0] dcnt;
		logic [3:0][3:0][23:0] tap;
		logic [3:0][1:0] fcnt;
		logic [23:0] hx;
		logic [23:0] hy;
		dfc_sample_t out;
	} dfc_state_t;
endpackage : dfc_pkg

// ---- src/dfc_filter_chain.sv ----
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "dfc_defines.svh"
module dfc_filter_chain (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic mod_bit_i,
	input wire logic ovr_cmp_i,
	output logic overrange_flag_o,
	output dfc_pkg::dfc_sample_t sample_o
);
	dfc_pkg::dfc_state_t st_r;
	dfc_pkg::dfc_state_t st_nxt;

	// stage weight tables: sub-stages 0,1 fixed, 2,3 follow phase
	function automatic logic [15:0] dfc_weights(input logic [1:0] stg,
		input logic ph);
		logic [15:0] w;
		w = `DFC_W_HALF;
		if (stg == 2'h2) begin
			w = ph ? `DFC_W_S3_MIN : `DFC_W_S3_LIN;
		end else if (stg == 2'h3) begin
			w = ph ? `DFC_W_S4_MIN : `DFC_W_S4_LIN;
		end
		return w;
	endfunction : dfc_weights

	// decimation of each fir sub-stage minus one
	function automatic logic [1:0] dfc_dec_last(input logic [1:0] stg);
		return (stg == 2'h2) ? 2'h3 : 2'h1;
	endfunction : dfc_dec_last

	logic mod_tick;
	logic w_ok;
	logic [2:0] rate_eff;
	logic [2:0] log2n;
	logic [6:0] dec_last;
	logic signed [36:0] x_in;
	logic signed [36:0] cv;
	logic signed [36:0] cd;
	logic signed [63:0] norm;
	logic [23:0] sinc_val;
	logic sinc_v;
	logic [3:0] st_v;
	logic [3:0][23:0] st_d;
	logic [23:0] stg_in;
	logic stg_in_v;
	logic [15:0] wt;
	logic signed [29:0] acc;
	logic signed [24:0] hdiff;
	logic signed [25:0] hsum;
	logic signed [41:0] hprod;
	logic signed [25:0] hnew;
	logic [23:0] hpf_val;
	logic [15:0] hp_coeff;
	integer k;

	assign mod_tick = (st_r.div == `DFC_MOD_DIV);
	assign w_ok = wb_cyc_i & wb_stb_i & ~st_r.ack;
	// codes above the last legal one run at the fastest rate
	assign rate_eff = (st_r.rate > `DFC_RATE_MAX) ? `DFC_RATE_MAX : st_r.rate;
	assign log2n = `DFC_LOG2N_MAX - rate_eff;
	assign dec_last = 7'((8'h80 >> rate_eff) - 8'h01);
	// one spare bit so a full N=128 sum of ones (2^35) stays positive
	assign x_in = mod_bit_i ? 37'sd1 : -37'sd1;
	assign hp_coeff = {st_r.hp_hi, st_r.hp_lo};

	always_comb begin
		st_nxt = st_r;
		cv = '0;
		cd = '0;
		norm = '0;
		sinc_val = '0;
		sinc_v = 1'b0;
		st_v = '0;
		st_d = '0;
		stg_in = '0;
		stg_in_v = 1'b0;
		wt = '0;
		acc = '0;
		hdiff = '0;
		hsum = '0;
		hprod = '0;
		hnew = '0;
		hpf_val = '0;
		st_nxt.out.valid = 1'b0;

		// wishbone slave: one wait state, ack drops the cycle after
		st_nxt.ack = w_ok;
		if (w_ok) begin
			st_nxt.rdat = '0;
			unique case (wb_adr_i)
			`DFC_ADR_CTRL: begin
				st_nxt.rdat[`DFC_CTRL_PHASE_BIT:0] = {st_r.phase,
					st_r.rate, st_r.path};
				if (wb_we_i && wb_sel_i[0]) begin
					st_nxt.path = dfc_pkg::dfc_path_t'(
						wb_dat_i[`DFC_CTRL_PATH_LSB +: 2]);
					st_nxt.rate = wb_dat_i[`DFC_CTRL_RATE_LSB +: 3];
					st_nxt.phase = wb_dat_i[`DFC_CTRL_PHASE_BIT];
				end
			end
			`DFC_ADR_HP_HI: begin
				st_nxt.rdat[7:0] = st_r.hp_hi;
				if (wb_we_i && wb_sel_i[0]) begin
					st_nxt.hp_hi = wb_dat_i[7:0];
				end
			end
			`DFC_ADR_HP_LO: begin
				st_nxt.rdat[7:0] = st_r.hp_lo;
				if (wb_we_i && wb_sel_i[0]) begin
					st_nxt.hp_lo = wb_dat_i[7:0];
				end
			end
			`DFC_ADR_STATUS: st_nxt.rdat[0] = st_r.flag;
			`DFC_ADR_DATA: st_nxt.rdat[23:0] = st_r.out.data;
			default: st_nxt.rdat = '0; // unmapped reads zero, writes drop
			endcase
		end

		// modulator rate divider, free running
		st_nxt.div = 2'(st_r.div + 2'h1);

		// flag refreshes every second modulator tick, so it holds
		// at least one such period once set; a one-tick over-range between refreshes is missed
		if (mod_tick) begin
			st_nxt.half = ~st_r.half;
			if (st_r.half) begin
				st_nxt.flag = ovr_cmp_i;
			end
		end

		// raw path: filters frozen to save power, bit passes straight
		if (st_r.path == dfc_pkg::DFC_PATH_RAW) begin
			if (mod_tick) begin
				st_nxt.out.valid = 1'b1;
				st_nxt.out.data = mod_bit_i ? `DFC_FULL_POS : `DFC_FULL_NEG;
			end
		end else if (mod_tick) begin
			// sinc: five integrators at the modulator rate
			st_nxt.integ[0] = 37'(st_r.integ[0] + x_in);
			for (k = 1; k < `DFC_ORDER; k++) begin
				st_nxt.integ[k] = 37'(st_r.integ[k] + st_nxt.integ[k-1]);
			end
			// five combs at the decimated rate put the notches at
			// the output rate and its multiples
			if (st_r.dcnt >= dec_last) begin
				st_nxt.dcnt = '0;
				cv = st_nxt.integ[`DFC_ORDER-1];
				for (k = 0; k < `DFC_ORDER; k++) begin
					cd = 37'(cv - st_r.comb[k]);
					st_nxt.comb[k] = cv;
					cv = cd;
				end
				// divide by N^5, then scale full scale to 24 bits
				norm = (64'(cv) <<< `DFC_NORM_BITS) >>> (`DFC_ORDER * log2n);
				if (norm > 64'(signed'(`DFC_FULL_POS))) begin
					sinc_val = `DFC_FULL_POS;
				end else if (norm < -64'(signed'(`DFC_FULL_POS))) begin
					sinc_val = `DFC_FULL_NEG;
				end else begin
					sinc_val = norm[23:0];
				end
				sinc_v = 1'b1;
			end else begin
				st_nxt.dcnt = 7'(st_r.dcnt + 7'h01);
			end
		end

		// fir: four chained sub-stages, each a four-tap section
		// decimating on its own counter; only the half and linear sets are symmetric
		for (k = 0; k < 4; k++) begin
			if (k == 0) begin
				stg_in = sinc_val;
				stg_in_v = sinc_v;
			end else begin
				stg_in = st_d[k-1];
				stg_in_v = st_v[k-1];
			end
			if (stg_in_v) begin
				st_nxt.tap[k] = {st_r.tap[k][2:0], stg_in};
				if (st_r.fcnt[k] >= dfc_dec_last(2'(k))) begin
					st_nxt.fcnt[k] = '0;
					wt = dfc_weights(2'(k), st_r.phase);
					acc = '0;
					for (int t = 0; t < 4; t++) begin
						acc = 30'(acc + 30'(signed'(st_nxt.tap[k][t])) *
							30'(signed'({1'b0, wt[4*t +: 4]})));
					end
					st_d[k] = 24'(acc >>> `DFC_COEF_SHIFT);
					st_v[k] = 1'b1;
				end else begin
					st_nxt.fcnt[k] = 2'(st_r.fcnt[k] + 2'h1);
				end
			end
		end

		// first-order iir high-pass: y = a*(y' + x - x'), a = 1 - c/65536
		if (st_v[3]) begin
			hdiff = 25'(signed'(st_d[3])) - 25'(signed'(st_r.hx));
			hsum = 26'(signed'(st_r.hy)) + 26'(hdiff);
			hprod = 42'(hsum) * 42'(signed'({1'b0, hp_coeff}));
			hnew = 26'(hsum - 26'(hprod >>> `DFC_HP_SHIFT));
			if (hnew > 26'(signed'(`DFC_FULL_POS))) begin
				hpf_val = `DFC_FULL_POS;
			end else if (hnew < -26'(signed'(`DFC_FULL_POS))) begin
				hpf_val = `DFC_FULL_NEG;
			end else begin
				hpf_val = hnew[23:0];
			end
			st_nxt.hx = st_d[3];
			st_nxt.hy = hpf_val;
		end

		// output source picked by the path field
		unique case (st_r.path)
		dfc_pkg::DFC_PATH_RAW: ;
		dfc_pkg::DFC_PATH_SINC: begin
			if (sinc_v) begin
				st_nxt.out.valid = 1'b1;
				st_nxt.out.data = sinc_val;
			end
		end
		dfc_pkg::DFC_PATH_FIR: begin
			if (st_v[3]) begin
				st_nxt.out.valid = 1'b1;
				st_nxt.out.data = st_d[3];
			end
		end
		dfc_pkg::DFC_PATH_HPF: begin
			if (st_v[3]) begin
				st_nxt.out.valid = 1'b1;
				st_nxt.out.data = hpf_val;
			end
		end
		endcase
	end

	// single state register; reset clears the filter memory too
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '0;
			st_r.hp_hi <= 8'(`DFC_HP_RESET >> 8);
			st_r.hp_lo <= 8'(`DFC_HP_RESET);
		end else begin
			st_r <= st_nxt;
		end
	end

	assign wb_ack_o = st_r.ack;
	assign wb_dat_o = st_r.rdat;
	assign overrange_flag_o = st_r.flag;
	assign sample_o = st_r.out;
endmodule : dfc_filter_chain
`default_nettype wire

// ---- test/dfc_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module dfc_filter_chain_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic overrange_flag_o,
	input wire dfc_pkg::dfc_sample_t sample_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [1:0] path_r;
	// path mirror lags a cycle; ctrl writes without sel bit 0 are not tracked
	always_ff @(posedge clk_i) begin
		if (rst_i)
			path_r <= 2'h0;
		else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00)
			path_r <= wb_dat_i[1:0];
	end
	a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_flag_rise_hold: assert property (
		$rose(overrange_flag_o) |-> overrange_flag_o [*8])
		else $error("flag pulse short");
	a_flag_fall_hold: assert property (
		$fell(overrange_flag_o) |-> !overrange_flag_o [*8])
		else $error("flag gap short");
	a_raw_period: assert property (sample_o.valid && path_r == 2'h0
		|=> !sample_o.valid [*3] ##1 (sample_o.valid || path_r != 2'h0))
		else $error("raw rate wrong");
	a_raw_code: assert property (sample_o.valid && path_r == 2'h0 |->
		sample_o.data == 24'h7fffff || sample_o.data == 24'h800001)
		else $error("raw code wrong");
	a_status_flag: assert property (
		wb_ack_o && !wb_we_i && wb_adr_i == 8'h0c
		|-> wb_dat_o[0] == $past(overrange_flag_o))
		else $error("status flag wrong");
	a_sinc_gap: assert property (
		sample_o.valid && path_r == 2'h1 |=> !sample_o.valid [*8])
		else $error("sinc rate wrong");
	c_flag: cover property ($rose(overrange_flag_o));
	c_sinc: cover property (sample_o.valid && path_r == 2'h1);
	c_read: cover property (wb_ack_o && !wb_we_i);
endmodule : dfc_filter_chain_props
bind dfc_filter_chain dfc_filter_chain_props u_props (.clk_i(clk_i),
	.rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.overrange_flag_o(overrange_flag_o), .sample_o(sample_o));
`default_nettype wire

// ---- test/dfc_mod_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// modulator and comparator stand-in, level in percent of full scale
module dfc_mod_model (
	input wire logic clk_i,
	input wire logic [7:0] level_i,
	output logic mod_bit_o,
	output logic ovr_cmp_o
);
	// saturated bitstream; comparator trips past full scale only
	always_ff @(posedge clk_i) begin
		mod_bit_o <= level_i >= 8'h32;
		ovr_cmp_o <= level_i > 8'h64;
	end
endmodule : dfc_mod_model
`default_nettype wire

// ---- test/tb_decimation_filter_chain.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_decimation_filter_chain;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} dfc_row_t;
	logic clk_i, rst_i, cyc, stb, we, mb, oc, flag, ack;
	logic [7:0] adr, level;
	logic [31:0] dat, rdat, q;
	dfc_pkg::dfc_sample_t smp;
	int fail_count, checks_done, g, i;
	// register defaults, unmapped place, coefficient bytes 019a
	dfc_row_t rows [10] = '{'{1'h0, 8'h00, 32'h0}, '{1'h0, 8'h04, 32'h3},
		'{1'h0, 8'h08, 32'h37}, '{1'h0, 8'h0c, 32'h0},
		'{1'h1, 8'h40, 32'hff}, '{1'h0, 8'h40, 32'h0},
		'{1'h1, 8'h04, 32'h1}, '{1'h1, 8'h08, 32'h9a},
		'{1'h0, 8'h04, 32'h1}, '{1'h0, 8'h08, 32'h9a}};
	dfc_filter_chain uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .mod_bit_i(mb),
		.ovr_cmp_i(oc), .overrange_flag_o(flag), .sample_o(smp));
	dfc_mod_model model (.clk_i(clk_i), .level_i(level), .mod_bit_o(mb),
		.ovr_cmp_o(oc));
	initial begin
		clk_i = 1'h0;
		forever #10 clk_i = !clk_i;
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	// every wait is bounded; running out of a bus or sample wait ends the run
	task automatic tmo(input logic hit);
		if (hit) begin
			fail_count++;
			tally_and_finish();
		end
	endtask : tmo
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		dat <= d;
		g = 0;
		do begin
			@(posedge clk_i);
			g++;
		end while (ack !== 1'h1 && g < 50);
		tmo(g >= 50);
		q = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
		@(posedge clk_i);
	endtask : bus
	// g ends as the cycle count since the previous sample
	task automatic wv();
		g = 0;
		do begin
			@(posedge clk_i);
			g++;
		end while (smp.valid !== 1'h1 && g < 5000);
		tmo(g >= 5000);
	endtask : wv
	task automatic wf(input logic e);
		g = 0;
		do begin
			@(posedge clk_i);
			g++;
		end while (flag !== e && g < 20);
		chk({31'h0, flag}, {31'h0, e});
	endtask : wf
	initial begin
		rst_i = 1'h1;
		cyc = 1'h0;
		stb = 1'h0;
		we = 1'h0;
		adr = 8'h00;
		dat = 32'h0;
		level = 8'h5a;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'h0;
		for (i = 0; i < 10; i++) begin
			bus(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w)
				chk(q, rows[i].d);
		end
		repeat (2) wv();
		chk(g, 4);
		chk(smp.data, 32'h7fffff);
		level <= 8'h00;
		repeat (4) wv();
		chk(smp.data, 32'h800001);
		level <= 8'h5a;
		// sinc at the shortest ratio, then the longest
		bus(1'h1, 8'h00, 32'h11);
		repeat (12) wv();
		chk(g, 32);
		chk(smp.data, 32'h7fffff);
		bus(1'h1, 8'h00, 32'h01);
		repeat (6) wv();
		chk(g, 512);
		chk(smp.data, 32'h7fffff);
		// fir in both phases
		bus(1'h1, 8'h00, 32'h32);
		repeat (3) wv();
		chk(g, 1024);
		bus(1'h1, 8'h00, 32'h12);
		repeat (2) wv();
		chk(g, 1024);
		// large coefficient so dc dies out within tens of samples
		bus(1'h1, 8'h04, 32'h80);
		bus(1'h1, 8'h08, 32'h0);
		bus(1'h1, 8'h00, 32'h33);
		repeat (40) wv();
		chk({31'h0, $signed(smp.data) < 24'sh40 && $signed(smp.data) > -24'sh40}, 32'h1);
		level <= 8'h6e;
		wf(1'h1);
		bus(1'h0, 8'h0c, 32'h0);
		chk(q, 32'h1);
		level <= 8'h5a;
		wf(1'h0);
		// reset in mid-run restores defaults
		bus(1'h1, 8'h00, 32'h2a);
		rst_i <= 1'h1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'h0;
		bus(1'h0, 8'h00, 32'h0);
		chk(q, 32'h0);
		tally_and_finish();
	end
endmodule : tb_decimation_filter_chain
`default_nettype wire
